// File: synth_mixer_control_regs.sv
// synth/mixer control register bank loaded by serial words or by the software port
`timescale 1ns/1ps

module synth_mixer_control_regs
  import synth_regs_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // serial programming link (asynchronous pins)
  input  wire logic        link_clk,
  input  wire logic        link_data,
  input  wire logic        link_load,
  // software port
  input  wire logic [3:0]  addr,
  input  wire logic [23:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [23:0]      rdata,
  // internal monitor sources
  input  wire logic        lock_detect,
  input  wire logic [6:0]  monitor_sources,
  input  wire logic [5:0]  band_cal_result,
  // analog controls
  output dither_t          dither_ctl,
  output pump_ref_t        pump_ref_ctl,
  output lo_mixer_t        lo_mixer_ctl,
  output osc_t             osc_ctl,
  output logic [5:0]       tuning_band,
  output logic [2:0]       pump_current_multiplier,
  output logic             monitor_output_pin
);

  typedef struct packed {
    link_t       link;
    dither_t     dither;
    pump_ref_t   pump;
    lo_mixer_t   lo;
    osc_t        osc;
    logic [5:0]  band;
    logic [2:0]  mult;
    logic        mon;
    logic [23:0] rdata;
  } state_t;

  state_t state_r;
  state_t state_nxt;

  localparam state_t STATE_RESET = '{
    link:   '0,
    dither: '{restart: DITH_RESET},
    pump:   '{mon_sel: MON_LOCK_DETECT, ref_scale: REF_UNITY, rset_external: 1'b0,
              phase_negative: 1'b0, phase_offset_multiplier: 5'h00,
              pump_current_multiplier: 2'h0},
    lo:     '{distortion_comp_setting: 4'h0, mixer_bias_enable: 1'b1, synth_enable: 1'b1,
              prescale_div3: 1'b0, lo_external: 1'b0, lo_driver_enable: 1'b0},
    osc:    '{charge_pump_enable: 1'b1, main_regulator_enable: 1'b1,
              oscillator_regulator_enable: 1'b1, oscillator_enable: 1'b1,
              switch_calibrate: 1'b0, oscillator_swing_level: SWING_RESET,
              band_source_select: 1'b0, tuning_band_manual: 6'h00},
    band:   6'h00,
    mult:   3'h1,
    mon:    1'b0,
    rdata:  24'h000000
  };

  // applies one 24-bit word to the register its select code names
  function automatic state_t apply_word(input state_t s, input logic [23:0] w);
    state_t t;
    t = s;
    unique case (w[2:0])
      SEL_DITHER: begin
        t.dither.restart = w[DITH_LSB +: DITH_W];
      end
      SEL_PUMP_REF: begin
        t.pump.pump_current_multiplier = w[PUMP_MULT_LSB +: 2];
        t.pump.phase_offset_multiplier = w[PHASE_OFS_LSB +: 5];
        t.pump.phase_negative = w[PHASE_POL_BIT];
        t.pump.rset_external = w[PUMP_RSET_BIT];
        t.pump.ref_scale = w[REF_SCALE_LSB +: 2];
        t.pump.mon_sel = w[MON_SEL_LSB +: 3];
      end
      SEL_LO_MIXER: begin
        t.lo.lo_driver_enable = w[LO_DRV_BIT];
        t.lo.lo_external = w[LO_EXT_BIT];
        t.lo.prescale_div3 = w[LO_DIV3_BIT];
        t.lo.synth_enable = w[SYN_EN_BIT];
        t.lo.mixer_bias_enable = w[MIX_BIAS_BIT];
        t.lo.distortion_comp_setting = w[DIST_COMP_LSB +: 4];
      end
      SEL_OSC_ENA: begin
        t.osc.tuning_band_manual = w[BAND_LSB +: 6];
        t.osc.band_source_select = w[BAND_SRC_BIT];
        t.osc.oscillator_swing_level = w[SWING_LSB +: 6];
        t.osc.switch_calibrate = w[SWITCH_BIT];
        t.osc.oscillator_enable = w[OSC_EN_BIT];
        t.osc.oscillator_regulator_enable = w[OSC_REG_BIT];
        t.osc.main_regulator_enable = w[MAIN_REG_BIT];
        t.osc.charge_pump_enable = w[PUMP_EN_BIT];
      end
      default: begin
        t = s;
      end
    endcase
    return t;
  endfunction

  always_comb begin
    logic sclk_rise;
    logic le_rise;
    logic [23:0] word;
    sclk_rise = 1'b0;
    le_rise = 1'b0;
    word = 24'h000000;
    state_nxt = state_r;
    // two-flop synchronisers; only the second stage is read
    state_nxt.link.sclk_s = {state_r.link.sclk_s[0], link_clk};
    state_nxt.link.sdata_s = {state_r.link.sdata_s[0], link_data};
    state_nxt.link.sle_s = {state_r.link.sle_s[0], link_load};
    state_nxt.link.sclk_d = state_r.link.sclk_s[1];
    state_nxt.link.le_d = state_r.link.sle_s[1];
    sclk_rise = state_r.link.sclk_s[1] & ~state_r.link.sclk_d;
    le_rise = state_r.link.sle_s[1] & ~state_r.link.le_d;
    // msb first shift on link clock rise
    if (sclk_rise) begin
      state_nxt.link.shift = {state_r.link.shift[22:0], state_r.link.sdata_s[1]};
    end
    // latch word on rising load edge; software write takes precedence in same cycle
    if (wr) begin
      state_nxt = apply_word(state_nxt, {wdata[23:3], addr[2:0]});
    end else if (le_rise) begin
      word = state_r.link.shift;
      state_nxt = apply_word(state_nxt, word);
      state_nxt.link.last_word = word;
      state_nxt.link.word_count = state_r.link.word_count + 8'h01;
    end
    // derived outputs
    state_nxt.mult = {1'b0, state_nxt.pump.pump_current_multiplier} + 3'h1;
    state_nxt.band = state_nxt.osc.band_source_select ?
                     state_nxt.osc.tuning_band_manual : band_cal_result;
    if (state_r.pump.mon_sel == MON_LOCK_DETECT) begin
      state_nxt.mon = lock_detect;
    end else begin
      state_nxt.mon = monitor_sources[3'(state_r.pump.mon_sel - 3'h1)];
    end
    // software read port, data one cycle later
    state_nxt.rdata = 24'h000000;
    if (rd) begin
      unique case (addr)
        OFS_DITHER:    state_nxt.rdata = {state_r.dither.restart, SEL_DITHER, 4'h0};
        OFS_PUMP_REF:  state_nxt.rdata = {state_r.pump, 7'h00, SEL_PUMP_REF};
        OFS_LO_MIXER:  state_nxt.rdata = {12'h000, state_r.lo, SEL_LO_MIXER};
        OFS_OSC_ENA:   state_nxt.rdata = {3'h0, state_r.osc, SEL_OSC_ENA};
        OFS_STATUS:    state_nxt.rdata = {10'h000, state_r.band, state_r.link.word_count};
        OFS_LAST_WORD: state_nxt.rdata = state_r.link.last_word;
        default:       state_nxt.rdata = 24'h000000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= STATE_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign rdata = state_r.rdata;
  assign dither_ctl = state_r.dither;
  assign pump_ref_ctl = state_r.pump;
  assign lo_mixer_ctl = state_r.lo;
  assign osc_ctl = state_r.osc;
  assign tuning_band = state_r.band;
  assign pump_current_multiplier = state_r.mult;
  assign monitor_output_pin = state_r.mon;

endmodule

// File: synth_regs_pkg.sv
// package: word decode, field positions and register layouts for the synth control bank
package synth_regs_pkg;

  localparam int WORD_W = 24;
  localparam int SEL_W  = 3;

  // register select codes
  localparam logic [2:0] SEL_INT_DIV   = 3'h0;
  localparam logic [2:0] SEL_DITHER    = 3'h3;
  localparam logic [2:0] SEL_PUMP_REF  = 3'h4;
  localparam logic [2:0] SEL_LO_MIXER  = 3'h5;
  localparam logic [2:0] SEL_OSC_ENA   = 3'h6;

  // software port offsets (word index on the plain port)
  localparam logic [3:0] OFS_DITHER    = 4'h3;
  localparam logic [3:0] OFS_PUMP_REF  = 4'h4;
  localparam logic [3:0] OFS_LO_MIXER  = 4'h5;
  localparam logic [3:0] OFS_OSC_ENA   = 4'h6;
  localparam logic [3:0] OFS_STATUS    = 4'h8;
  localparam logic [3:0] OFS_LAST_WORD = 4'h9;

  // dither restart field
  localparam int DITH_LSB = 3;
  localparam int DITH_W   = 17;

  // pump/reference fields
  localparam int PUMP_MULT_LSB = 10;
  localparam int PHASE_OFS_LSB = 12;
  localparam int PHASE_POL_BIT = 17;
  localparam int PUMP_RSET_BIT = 18;
  localparam int REF_SCALE_LSB = 19;
  localparam int MON_SEL_LSB   = 21;
  localparam int BASE_CURRENT_UA = 250;

  // LO path fields
  localparam int LO_DRV_BIT    = 3;
  localparam int LO_EXT_BIT    = 4;
  localparam int LO_DIV3_BIT   = 5;
  localparam int SYN_EN_BIT    = 6;
  localparam int MIX_BIAS_BIT  = 7;
  localparam int DIST_COMP_LSB = 8;

  // oscillator fields
  localparam int BAND_LSB      = 3;
  localparam int BAND_SRC_BIT  = 9;
  localparam int SWING_LSB     = 10;
  localparam int SWITCH_BIT    = 16;
  localparam int OSC_EN_BIT    = 17;
  localparam int OSC_REG_BIT   = 18;
  localparam int MAIN_REG_BIT  = 19;
  localparam int PUMP_EN_BIT   = 20;

  // reset values
  localparam logic [2:0] MON_LOCK_DETECT = 3'h0;
  localparam logic [1:0] REF_UNITY       = 2'h1;
  localparam logic [5:0] SWING_RESET     = 6'h2F;
  localparam logic [16:0] DITH_RESET     = 17'h00001;

  typedef enum logic [1:0] {REF_X2, REF_X1, REF_X05, REF_X025} ref_scale_t;

  typedef struct packed {
    logic [16:0] restart;
  } dither_t;

  typedef struct packed {
    logic [2:0] mon_sel;
    logic [1:0] ref_scale;
    logic       rset_external;
    logic       phase_negative;
    logic [4:0] phase_offset_multiplier;
    logic [1:0] pump_current_multiplier;
  } pump_ref_t;

  typedef struct packed {
    logic [3:0] distortion_comp_setting;
    logic       mixer_bias_enable;
    logic       synth_enable;
    logic       prescale_div3;
    logic       lo_external;
    logic       lo_driver_enable;
  } lo_mixer_t;

  typedef struct packed {
    logic       charge_pump_enable;
    logic       main_regulator_enable;
    logic       oscillator_regulator_enable;
    logic       oscillator_enable;
    logic       switch_calibrate;
    logic [5:0] oscillator_swing_level;
    logic       band_source_select;
    logic [5:0] tuning_band_manual;
  } osc_t;

  // serial frame state: shift register, last word, word count, synchronisers
  typedef struct packed {
    logic [1:0]  sclk_s;
    logic [1:0]  sdata_s;
    logic [1:0]  sle_s;
    logic        sclk_d;
    logic        le_d;
    logic [23:0] shift;
    logic [23:0] last_word;
    logic [7:0]  word_count;
  } link_t;

endpackage

// File: synth_mixer_control_regs_monitor.sv
// checker: port-level properties of the synth control bank
`timescale 1ns/1ps
module synth_ctl_checker
  import synth_regs_pkg::*;
(
  // clock, reset and software port
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [3:0]  addr,
  input wire logic [23:0] wdata,
  input wire logic        wr,
  // sources and controls
  input wire logic        lock_detect,
  input wire logic [5:0]  band_cal_result,
  input wire dither_t     dither_ctl,
  input wire pump_ref_t   pump_ref_ctl,
  input wire lo_mixer_t   lo_mixer_ctl,
  input wire osc_t        osc_ctl,
  input wire logic [5:0]  tuning_band,
  input wire logic [2:0]  pump_current_multiplier,
  input wire logic        monitor_output_pin
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_dither_load:
    assert property (wr && addr == OFS_DITHER |=> dither_ctl == $past(wdata[19:3]))
    else $error("dither write lost");
  a_pump_load:
    assert property (wr && addr == OFS_PUMP_REF |=> pump_ref_ctl == $past(wdata[23:10]))
    else $error("pump write lost");
  a_lo_load:
    assert property (wr && addr == OFS_LO_MIXER |=> lo_mixer_ctl == $past(wdata[11:3]))
    else $error("lo write lost");
  a_osc_load:
    assert property (wr && addr == OFS_OSC_ENA |=> osc_ctl == $past(wdata[20:3]))
    else $error("osc write lost");
  a_others_kept:
    assert property (wr && addr == OFS_LO_MIXER |=> $stable(dither_ctl) && $stable(osc_ctl)
      && $stable(pump_ref_ctl)) else $error("other register changed");
  a_bad_sel_kept:
    assert property (wr && addr[2:0] inside {3'h0, 3'h1, 3'h2, 3'h7} |=> $stable(lo_mixer_ctl)
      && $stable(osc_ctl) && $stable(pump_ref_ctl)) else $error("bad select applied");
  a_mult_plus_one:
    assert property (pump_current_multiplier == 3'(pump_ref_ctl.pump_current_multiplier) + 3'h1)
    else $error("multiplier wrong");
  a_band_pick:
    assert property ($past(rst_n) |-> tuning_band == (osc_ctl.band_source_select ?
      osc_ctl.tuning_band_manual : $past(band_cal_result))) else $error("band source wrong");
  a_mon_lock:
    assert property ($past(rst_n) && $past(pump_ref_ctl.mon_sel) == MON_LOCK_DETECT |->
      monitor_output_pin == $past(lock_detect)) else $error("monitor not lock detect");

  cover property (wr && addr == OFS_OSC_ENA);
  cover property (osc_ctl.band_source_select && tuning_band == osc_ctl.tuning_band_manual);
  cover property (pump_ref_ctl.mon_sel != MON_LOCK_DETECT && monitor_output_pin);
endmodule

bind synth_mixer_control_regs synth_ctl_checker synth_ctl_checker_i (
  .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .lock_detect(lock_detect),
  .band_cal_result(band_cal_result), .dither_ctl(dither_ctl), .pump_ref_ctl(pump_ref_ctl),
  .lo_mixer_ctl(lo_mixer_ctl), .osc_ctl(osc_ctl), .tuning_band(tuning_band),
  .pump_current_multiplier(pump_current_multiplier), .monitor_output_pin(monitor_output_pin));

// File: link_host_model.sv
// partner: host that shifts words into the serial programming link
`timescale 1ns/1ps
module link_host_model (
  // serial programming link
  output logic link_clk,
  output logic link_data,
  output logic link_load
);
  initial begin
    link_clk  = 1'b0;
    link_data = 1'b0;
    link_load = 1'b0;
  end
  // msb first, select code in the lowest three bits; clock idles low
  task automatic send(input logic [23:0] word);
    for (int i = 23; i >= 0; i--) begin
      link_data = word[i];
      #40 link_clk = 1'b1;
      #40 link_clk = 1'b0;
    end
    link_data = ~word[0];
    link_load = 1'b1;
    #80 link_load = 1'b0;
  endtask
endmodule

// File: tb_synth_mixer_control_regs.sv
// testbench: software and serial programming of the synth control bank
`timescale 1ns/1ps
module tb_synth_mixer_control_regs;
  import synth_regs_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [23:0] wdata = 24'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        lock_detect = 1'b0;
  logic [6:0]  monitor_sources = 7'h0;
  logic [5:0]  band_cal_result = 6'h15;
  logic [23:0] rdata, w, p;
  dither_t     dither_ctl;
  pump_ref_t   pump_ref_ctl;
  lo_mixer_t   lo_mixer_ctl;
  osc_t        osc_ctl;
  logic [5:0]  tuning_band;
  logic [2:0]  pump_current_multiplier;
  logic        monitor_output_pin, link_clk, link_data, link_load;
  int          err_count = 0;
  int          check_count = 0;

  always #5 clk = ~clk;

  synth_mixer_control_regs synth_mixer_control_regs_i (
    .clk(clk), .rst_n(rst_n), .link_clk(link_clk), .link_data(link_data),
    .link_load(link_load), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .lock_detect(lock_detect), .monitor_sources(monitor_sources),
    .band_cal_result(band_cal_result), .dither_ctl(dither_ctl), .pump_ref_ctl(pump_ref_ctl),
    .lo_mixer_ctl(lo_mixer_ctl), .osc_ctl(osc_ctl), .tuning_band(tuning_band),
    .pump_current_multiplier(pump_current_multiplier),
    .monitor_output_pin(monitor_output_pin));
  link_host_model link_host_model_i (.link_clk(link_clk), .link_data(link_data),
    .link_load(link_load));

  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [23:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [23:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("rdata", rdata, e);
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    #500000;
    err_count++;
    test_done();
  end

  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("dither", 24'(dither_ctl), 24'(DITH_RESET));
    chk("pump", 24'(pump_ref_ctl), {10'h0, MON_LOCK_DETECT, REF_UNITY, 9'h0});
    chk("osc", 24'(osc_ctl), {6'h0, 4'hF, 1'b0, SWING_RESET, 7'h0});
    chk("band", 24'(tuning_band), 24'h15);
    for (int k = 0; k < 4; k++) begin
      p = {3'h0, 2'(k), 1'(k), ~1'(k), 5'h11 + 5'(k), 2'(k), 7'h0, SEL_PUMP_REF};
      wr_reg(OFS_PUMP_REF, p);
      chk("pump", 24'(pump_ref_ctl), {10'h0, p[23:10]});
      chk("mult", 24'(pump_current_multiplier), 24'(k + 1));
    end
    rd_chk(OFS_PUMP_REF, p);
    wr_reg(OFS_DITHER, {4'h0, 17'h1FFFF, SEL_DITHER});
    chk("dither", 24'(dither_ctl), 24'h1FFFF);
    w = {12'h0, 4'hA, 5'b00111, SEL_LO_MIXER};
    link_host_model_i.send(w);
    repeat (8) @(posedge clk);
    #1 chk("lo", 24'(lo_mixer_ctl), 24'(w[11:3]));
    chk("pump", 24'(pump_ref_ctl), {10'h0, p[23:10]});
    rd_chk(OFS_LAST_WORD, w);
    wr_reg(OFS_LO_MIXER, {12'h0, 4'h5, 5'b11000, SEL_LO_MIXER});
    chk("lo", 24'(lo_mixer_ctl), 24'h0B8);
    w = {3'h0, 4'b0010, 1'b0, 6'h3F, 1'b1, 6'h2A, SEL_OSC_ENA};
    wr_reg(OFS_OSC_ENA, w);
    chk("osc", 24'(osc_ctl), 24'(w[20:3]));
    chk("band", 24'(tuning_band), 24'h2A);
    wr_reg(OFS_OSC_ENA, {3'h0, 4'b1111, 1'b0, 6'h2F, 1'b0, 6'h2A, SEL_OSC_ENA});
    @(posedge clk);
    band_cal_result <= 6'h0C;
    repeat (2) @(posedge clk);
    #1 chk("band", 24'(tuning_band), 24'h0C);
    w = {21'h1FFFFF, SEL_INT_DIV};
    link_host_model_i.send(w);
    wr_reg(4'h7, 24'hFFFFFF);
    repeat (8) @(posedge clk);
    #1 chk("lo", 24'(lo_mixer_ctl), 24'h0B8);
    chk("dither", 24'(dither_ctl), 24'h1FFFF);
    rd_chk(4'hF, 24'h0);
    rd_chk(OFS_STATUS, {10'h0, 6'h0C, 8'h02});
    @(posedge clk);
    lock_detect <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk("monitor", 24'(monitor_output_pin), 24'h1);
    wr_reg(OFS_PUMP_REF, {3'h3, p[20:0]});
    @(posedge clk);
    lock_detect     <= 1'b0;
    monitor_sources <= 7'h04;
    repeat (2) @(posedge clk);
    #1 chk("monitor", 24'(monitor_output_pin), 24'h1);
    test_done();
  end
endmodule
